// *** bench/diag_regs_assertions.sv ***
// checker: port relations of the diagnostic register bank
// assumes: bound to diag_mux_selftest_regs, one clock, async low reset
`default_nettype none
module diag_regs_assertions (
    input wire logic clk_i, // clock
    input wire logic resetn_i, // reset, low
    input wire logic word_valid_i, // word strobe
    input wire logic [15:0] word_i, // access word
    input wire logic [15:0] reply_o, // answer word
    input wire logic reply_valid_o, // answer pulse
    input wire logic parity_error_o, // reject pulse
    input wire logic builtin_selftest_failed_set_i, // bist set
    input wire logic [6:0] status_zero_set_i, // zero sets
    input wire logic [3:0] status_one_set_i, // one sets
    input wire logic [3:0] analog_source_select_o, // select
    input wire logic [11:0] source_enable_o, // switches
    input wire diag_regs_pkg::analog_divider_t divider_o, // scaling
    input wire logic builtin_selftest_failed_o, // bist flag
    input wire logic [6:0] status_zero_o, // zero flags
    input wire logic [3:0] status_one_o // one flags
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    logic good;
    assign good = word_valid_i && (^word_i);
    // ========================================================================
    // access handshake
    chk_reply_pulse: assert property (good |=> reply_valid_o)
        else $error("reply pulse missing");
    chk_parity_reject: assert property (word_valid_i && !(^word_i) |=>
        parity_error_o && !reply_valid_o && $stable(analog_source_select_o))
        else $error("bad parity word not refused");
    // ========================================================================
    // routing
    chk_select_write: assert property (good && word_i[15:10] == 6'h19 |=>
        analog_source_select_o == $past(word_i[4:1]))
        else $error("select not written");
    chk_route_onehot: assert property (analog_source_select_o < 4'hC |->
        source_enable_o == 12'h001 << analog_source_select_o)
        else $error("wrong source enabled");
    chk_half_scale: assert property (analog_source_select_o <= 4'h4 |->
        divider_o == diag_regs_pkg::DIV_HALF)
        else $error("rail not at half scale");
    chk_pump_scale: assert property (analog_source_select_o inside {4'hA, 4'hB} |->
        divider_o == diag_regs_pkg::DIV_TWELFTH)
        else $error("pump not at twelfth");
    // ========================================================================
    // flags: set wins over a clear in the same cycle
    chk_zero_clear: assert property (good && word_i[15:10] == 6'h1B |=>
        status_zero_o == (($past(status_zero_o) & ~$past(word_i[7:1]))
        | $past(status_zero_set_i)))
        else $error("status zero clear wrong");
    chk_one_clear: assert property (good && word_i[15:10] == 6'h1D |=>
        status_one_o == (($past(status_one_o) & ~$past(word_i[4:1]))
        | $past(status_one_set_i)))
        else $error("status one clear wrong");
    chk_flag_hold: assert property (!(good && word_i[10]) |=>
        status_one_o == ($past(status_one_o) | $past(status_one_set_i)))
        else $error("flag lost or not set");
    chk_bist_set: assert property (builtin_selftest_failed_set_i |=> builtin_selftest_failed_o)
        else $error("bist flag not set");
endmodule : diag_regs_assertions
bind diag_mux_selftest_regs diag_regs_assertions u_chk (.clk_i, .resetn_i,
    .word_valid_i, .word_i, .reply_o, .reply_valid_o, .parity_error_o,
    .builtin_selftest_failed_set_i, .status_zero_set_i, .status_one_set_i,
    .analog_source_select_o, .source_enable_o, .divider_o,
    .builtin_selftest_failed_o, .status_zero_o, .status_one_o);
`default_nettype wire

// *** bench/host_model.sv ***
// host model: hands one parity-protected access word to the bank
// assumes: same clock as the bank, answer one cycle after the word
`default_nettype none
module host_model (
    input wire logic clk_i, // bank clock
    input wire logic [15:0] reply_i, // answer word
    input wire logic reply_valid_i, // answer pulse
    input wire logic parity_error_i, // reject pulse
    output logic word_valid_o, // word strobe
    output logic [15:0] word_o // access word
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        word_valid_o = 1'b0;
        word_o = 16'h0000;
    end
    task automatic acc(input logic [4:0] a, input logic w,
        input logic [7:0] d, input logic bad, output logic [7:0] q,
        output logic [1:0] ans);
        logic [15:0] x;
        x = {a, w, 1'b0, d, 1'b0};
        x[0] = ~^x ^ bad; // odd parity over the word
        @(posedge clk_i);
        #1;
        word_o = x;
        word_valid_o = 1'b1;
        @(posedge clk_i);
        #1;
        word_valid_o = 1'b0;
        // released word shows its inverse, never a stale copy
        word_o = ~x;
        q = reply_i[8:1];
        ans = {reply_valid_i, parity_error_i};
    endtask : acc
endmodule : host_model
`default_nettype wire

// *** bench/tb_diag_mux_selftest_regs.sv ***
// testbench: register accesses through the host model, expected values
// assumes: design and package compiled first, checker bound
`default_nettype none
module tb_diag_mux_selftest_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic resetn_i, word_valid_i, reply_valid_o, parity_error_o;
    logic builtin_selftest_failed_set_i, builtin_selftest_failed_o;
    logic [15:0] word_i, reply_o;
    logic [6:0] status_zero_set_i, status_zero_o;
    logic [3:0] status_one_set_i, status_one_o, analog_source_select_o;
    logic [11:0] source_enable_o;
    diag_regs_pkg::analog_divider_t divider_o;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [7:0] q;
    logic [1:0] ans;
    logic [2:0] dv [12] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h2,
        3'h3, 3'h4, 3'h5, 3'h5};
    diag_mux_selftest_regs dut (.clk_i, .resetn_i, .word_valid_i, .word_i,
        .reply_o, .reply_valid_o, .parity_error_o, .builtin_selftest_failed_set_i,
        .status_zero_set_i, .status_one_set_i, .analog_source_select_o,
        .source_enable_o, .divider_o, .builtin_selftest_failed_o,
        .status_zero_o, .status_one_o);
    host_model host (.clk_i, .reply_i(reply_o), .reply_valid_i(reply_valid_o),
        .parity_error_i(parity_error_o), .word_valid_o(word_valid_i),
        .word_o(word_i));
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        host.acc(a, 1'b0, 8'h00, 1'b0, q, ans);
        chk("read", {8'h00, e}, {8'h00, q});
    endtask : rd
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        host.acc(a, 1'b1, d, 1'b0, q, ans);
        chk("answer", 16'h0002, 16'(ans));
    endtask : wr
    task automatic summarize();
        if (failures == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    initial begin
        resetn_i = 1'b0;
        builtin_selftest_failed_set_i = 1'b0;
        status_zero_set_i = 7'h00;
        status_one_set_i = 4'h0;
        repeat (4) @(posedge clk_i);
        #1;
        resetn_i = 1'b1;
        chk("enable", 16'h0001, 16'(source_enable_o));
        rd(5'h0C, 8'h00);
        rd(5'h0D, 8'h00);
        rd(5'h0E, 8'h00);
        chk("bist", 16'h0000, 16'(builtin_selftest_failed_o));
        for (int c = 0; c < 12; c++) begin
            wr(5'h0C, 8'hF0 | 8'(c));
            chk("enable", 16'(12'h001 << c), 16'(source_enable_o));
            chk("divider", 16'(dv[c]), 16'(divider_o));
            rd(5'h0C, 8'(c));
        end
        host.acc(5'h0C, 1'b1, 8'h03, 1'b1, q, ans);
        chk("reject", 16'h0001, 16'(ans));
        rd(5'h0C, 8'h0B);
        wr(5'h1F, 8'hFF);
        rd(5'h1F, 8'h00);
        #1;
        builtin_selftest_failed_set_i = 1'b1;
        status_zero_set_i = 7'h7F;
        status_one_set_i = 4'hF;
        @(posedge clk_i);
        #1;
        builtin_selftest_failed_set_i = 1'b0;
        status_zero_set_i = 7'h00;
        status_one_set_i = 4'h0;
        chk("bist", 16'h0001, 16'(builtin_selftest_failed_o));
        rd(5'h0D, 8'h7F);
        rd(5'h0E, 8'h0F);
        wr(5'h0D, 8'h01);
        rd(5'h0D, 8'h7E);
        wr(5'h0D, 8'h40);
        rd(5'h0D, 8'h3E);
        chk("bist", 16'h0000, 16'(builtin_selftest_failed_o));
        wr(5'h0E, 8'hF5);
        rd(5'h0E, 8'h0A);
        // set pulse and write-one clear in one cycle: the set must win
        fork
            host.acc(5'h0E, 1'b1, 8'h0F, 1'b0, q, ans);
            begin
                @(posedge clk_i);
                #1;
                status_one_set_i = 4'h1;
                @(posedge clk_i);
                #1;
                status_one_set_i = 4'h0;
            end
        join
        chk("answer", 16'h0002, 16'(ans));
        chk("set wins", 16'h0001, 16'(status_one_o));
        rd(5'h0E, 8'h01);
        wr(5'h0D, 8'h3E);
        rd(5'h0D, 8'h00);
        summarize();
    end
endmodule : tb_diag_mux_selftest_regs
`default_nettype wire

// *** design/analog_route_decode.sv ***
// analog routing decoder: select code to one-hot source enable and divider
// assumes: code comes from the select register on the same clock
`default_nettype none
module analog_route_decode (
    input wire logic [3:0] code_i, // analog source select
    output logic [11:0] source_enable_o, // one-hot switch enables
    output diag_regs_pkg::analog_divider_t divider_o // scaling to apply
);
    // ========================================================================
    // one-hot: codes 12..15 open every switch
    genvar g;
    generate
        for (g = 0; g < diag_regs_pkg::NUM_SOURCES; g++) begin : g_src
            assign source_enable_o[g] = (code_i == 4'(g));
        end
    endgenerate

    always_comb begin
        case (code_i)
            diag_regs_pkg::SRC_PREREG_OUTPUT,
            diag_regs_pkg::SRC_CPU_RAIL,
            diag_regs_pkg::SRC_GENERAL_RAIL,
            diag_regs_pkg::SRC_SENSOR_RAIL_A,
            diag_regs_pkg::SRC_SENSOR_RAIL_B: begin
                divider_o = diag_regs_pkg::DIV_HALF;
            end
            diag_regs_pkg::SRC_IGNITION_INPUT: begin
                divider_o = diag_regs_pkg::DIV_EIGHTH;
            end
            diag_regs_pkg::SRC_REFERENCE_A,
            diag_regs_pkg::SRC_REFERENCE_B: begin
                divider_o = diag_regs_pkg::DIV_UNITY;
            end
            diag_regs_pkg::SRC_TEMPERATURE: begin
                divider_o = diag_regs_pkg::DIV_NONE;
            end
            diag_regs_pkg::SRC_BATTERY_INPUT: begin
                divider_o = diag_regs_pkg::DIV_TENTH;
            end
            diag_regs_pkg::SRC_CHARGE_PUMP_A,
            diag_regs_pkg::SRC_CHARGE_PUMP_B: begin
                divider_o = diag_regs_pkg::DIV_TWELFTH;
            end
            default: begin
                divider_o = diag_regs_pkg::DIV_OFF;
            end
        endcase
    end
endmodule : analog_route_decode
`default_nettype wire

// *** design/diag_mux_selftest_regs.sv ***
// diagnostic register bank: analog monitor select and self-test flags
// assumes: the serial frame engine hands over one parallel 16-bit word per
// access with a one-cycle strobe on clk_i; self-test events are one-cycle
// pulses from the sequencer on the same clock
`default_nettype none
module diag_mux_selftest_regs (
    input wire logic clk_i, // 125 MHz clock
    input wire logic resetn_i, // async reset, active low
    input wire logic word_valid_i, // one-cycle strobe: word received
    input wire logic [15:0] word_i, // received access word
    output logic [15:0] reply_o, // answer word for the next frame
    output logic reply_valid_o, // one-cycle pulse: reply updated
    output logic parity_error_o, // one-cycle pulse: word rejected
    input wire logic builtin_selftest_failed_set_i, // pulse: built-in self-test failed
    input wire logic [6:0] status_zero_set_i, // pulses for status zero flags
    input wire logic [3:0] status_one_set_i, // pulses for status one flags
    output logic [3:0] analog_source_select_o, // routed source code
    output logic [11:0] source_enable_o, // one-hot analog switches
    output diag_regs_pkg::analog_divider_t divider_o, // scaling selection
    output logic builtin_selftest_failed_o, // built-in self-test result
    output logic [6:0] status_zero_o, // status zero flags
    output logic [3:0] status_one_o // status one flags
);
    // ========================================================================
    // word decode
    function automatic logic parity_ok(input logic [15:0] w);
        parity_ok = ((^w) == diag_regs_pkg::PARITY_ODD);
    endfunction : parity_ok

    function automatic logic [15:0] make_word(input logic [4:0] a,
                                              input logic [7:0] d);
        logic [15:0] w;
        w = {a, 1'b0, 1'b0, d, 1'b0};
        w[diag_regs_pkg::PARITY_BIT] = (^w) ^ diag_regs_pkg::PARITY_ODD;
        make_word = w;
    endfunction : make_word

    logic [4:0] acc_addr;
    logic acc_write;
    logic [7:0] acc_data;
    logic acc_ok;
    assign acc_addr = word_i[diag_regs_pkg::ADDR_HI:diag_regs_pkg::ADDR_LO];
    assign acc_write = word_i[diag_regs_pkg::TYPE_BIT]
                       == diag_regs_pkg::TYPE_WRITE;
    assign acc_data = word_i[diag_regs_pkg::DATA_HI:diag_regs_pkg::DATA_LO];
    assign acc_ok = word_valid_i && parity_ok(word_i);

    logic wr_select;
    logic wr_zero;
    logic wr_one;
    assign wr_select = acc_ok && acc_write
                       && acc_addr == diag_regs_pkg::ADDR_ANALOG_MONITOR_SELECT;
    assign wr_zero = acc_ok && acc_write
                     && acc_addr == diag_regs_pkg::ADDR_SELFTEST_STATUS_ZERO;
    assign wr_one = acc_ok && acc_write
                    && acc_addr == diag_regs_pkg::ADDR_SELFTEST_STATUS_ONE;

    // ========================================================================
    // analog select register
    logic [3:0] analog_select;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            analog_select <= diag_regs_pkg::RST_ANALOG_SELECT;
        end else if (wr_select) begin
            analog_select <= acc_data[3:0];
        end
    end
    assign analog_source_select_o = analog_select;

    analog_route_decode u_route (
        .code_i(analog_select),
        .source_enable_o(source_enable_o),
        .divider_o(divider_o)
    );

    // ========================================================================
    // self-test flags: set beats a write-one clear in the same cycle
    logic [6:0] status_zero;
    logic [3:0] status_one;
    logic builtin_selftest_failed;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            status_zero <= diag_regs_pkg::RST_STATUS_ZERO;
        end else begin
            status_zero <= (status_zero & ~(wr_zero ? acc_data[6:0] : 7'h00))
                           | status_zero_set_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            status_one <= diag_regs_pkg::RST_STATUS_ONE;
        end else begin
            status_one <= (status_one & ~(wr_one ? acc_data[3:0] : 4'h0))
                          | status_one_set_i;
        end
    end

    // no field of its own: cleared with the thermal bit of status zero
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            builtin_selftest_failed <= 1'b0;
        end else if (builtin_selftest_failed_set_i) begin
            builtin_selftest_failed <= 1'b1;
        end else if (wr_zero && acc_data[diag_regs_pkg::POS_THERMAL]) begin
            builtin_selftest_failed <= 1'b0;
        end
    end
    assign status_zero_o = status_zero;
    assign status_one_o = status_one;
    assign builtin_selftest_failed_o = builtin_selftest_failed;

    // ========================================================================
    // reply: register value before the access takes effect
    logic [7:0] read_data;
    always_comb begin
        case (acc_addr)
            diag_regs_pkg::ADDR_ANALOG_MONITOR_SELECT: begin
                read_data = {4'h0, analog_select};
            end
            diag_regs_pkg::ADDR_SELFTEST_STATUS_ZERO: begin
                read_data = {1'b0, status_zero};
            end
            diag_regs_pkg::ADDR_SELFTEST_STATUS_ONE: begin
                read_data = {4'h0, status_one};
            end
            default: begin
                read_data = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reply_o <= 16'h0000;
            reply_valid_o <= 1'b0;
            parity_error_o <= 1'b0;
        end else begin
            reply_valid_o <= acc_ok;
            parity_error_o <= word_valid_i && !parity_ok(word_i);
            if (acc_ok) begin
                reply_o <= make_word(acc_addr, read_data);
            end
        end
    end
endmodule : diag_mux_selftest_regs
`default_nettype wire

// *** include/diag_regs_pkg.sv ***
// package: register addresses, field positions, reset values and mux codes
// assumes: used as diag_regs_pkg::name by the register bank, its route decoder, the checker and the testbench
`default_nettype none
package diag_regs_pkg;
    // ========================================================================
    // register addresses (5-bit)
    localparam logic [4:0] ADDR_ANALOG_MONITOR_SELECT = 5'h0C;
    localparam logic [4:0] ADDR_SELFTEST_STATUS_ZERO = 5'h0D;
    localparam logic [4:0] ADDR_SELFTEST_STATUS_ONE = 5'h0E;
    // ========================================================================
    // word layout
    localparam int WORD_W = 16;
    localparam int ADDR_HI = 15;
    localparam int ADDR_LO = 11;
    localparam int TYPE_BIT = 10;
    localparam int DATA_HI = 8;
    localparam int DATA_LO = 1;
    localparam int PARITY_BIT = 0;
    // 1: write access
    localparam logic TYPE_WRITE = 1'b1;
    // 1: odd parity over the whole word
    localparam logic PARITY_ODD = 1'b1;
    // ========================================================================
    // reset values
    localparam logic [3:0] RST_ANALOG_SELECT = 4'h0;
    localparam logic [6:0] RST_STATUS_ZERO = 7'h00;
    localparam logic [3:0] RST_STATUS_ONE = 4'h0;
    // status zero field positions
    localparam int POS_THERMAL = 6;
    localparam int POS_PREREG_OV = 5;
    localparam int POS_PREREG_UV = 4;
    localparam int POS_CPU_OV = 3;
    localparam int POS_CPU_UV = 2;
    localparam int POS_GENERAL_OV = 1;
    localparam int POS_GENERAL_UV = 0;
    // status one field positions
    localparam int POS_SENSOR_A_OV = 3;
    localparam int POS_SENSOR_A_UV = 2;
    localparam int POS_SENSOR_B_OV = 1;
    localparam int POS_SENSOR_B_UV = 0;
    // ========================================================================
    // analog source codes
    typedef enum logic [3:0] {
        SRC_PREREG_OUTPUT = 4'h0,
        SRC_CPU_RAIL = 4'h1,
        SRC_GENERAL_RAIL = 4'h2,
        SRC_SENSOR_RAIL_A = 4'h3,
        SRC_SENSOR_RAIL_B = 4'h4,
        SRC_IGNITION_INPUT = 4'h5,
        SRC_REFERENCE_A = 4'h6,
        SRC_REFERENCE_B = 4'h7,
        SRC_TEMPERATURE = 4'h8,
        SRC_BATTERY_INPUT = 4'h9,
        SRC_CHARGE_PUMP_A = 4'hA,
        SRC_CHARGE_PUMP_B = 4'hB
    } analog_source_t;
    localparam int NUM_SOURCES = 12;
    // divider codes for the analog scaling stage
    typedef enum logic [2:0] {
        DIV_HALF = 3'h0,
        DIV_EIGHTH = 3'h1,
        DIV_UNITY = 3'h2,
        DIV_NONE = 3'h3,
        DIV_TENTH = 3'h4,
        DIV_TWELFTH = 3'h5,
        DIV_OFF = 3'h7
    } analog_divider_t;
endpackage : diag_regs_pkg
`default_nettype wire
